/* File: logic/fsp_poll_ctrl.sv */
// status polling controller for an asynchronous nor flash
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_poll_ctrl (
   // clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // flash pins
   output logic      [22:0] FLASH_ADDR,
   output logic             FLASH_CE_N,
   output logic             FLASH_OE_N,
   output logic             FLASH_WE_N,
   output logic      [15:0] FLASH_DQ_OUT,
   output logic             FLASH_DQ_OE,
   input  wire logic [15:0] FLASH_DQ_IN
);
   import fsp_pkg::*;
   logic        start_pulse;
   logic        reset_pulse;
   logic        use_toggle;
   logic [22:0] poll_addr;
   logic [15:0] prog_data;
   logic        ack;
   logic [15:0] rd_data;
   typedef struct packed {
      fsp_state_t  st;
      logic        req_rd;
      logic        req_wr;
      logic [15:0] first;
      logic [15:0] last;
      logic        busy;
      logic        done;
      logic        fail;
      logic        rst_done;
      logic        fail_seen;
   } fsp_top_st_t;
   fsp_top_st_t s_reg;
   fsp_top_st_t s_next;
   logic        poll_ok;
   logic        toggled;
   fsp_apb_slave u_apb (
      .clk         (CLK_SYS),
      .rst         (RESET),
      .psel        (PSEL),
      .penable     (PENABLE),
      .pwrite      (PWRITE),
      .paddr       (PADDR),
      .pwdata      (PWDATA),
      .prdata      (PRDATA),
      .pready      (PREADY),
      .pslverr     (PSLVERR),
      .start_pulse (start_pulse),
      .reset_pulse (reset_pulse),
      .use_toggle  (use_toggle),
      .poll_addr   (poll_addr),
      .prog_data   (prog_data),
      .status      ({s_reg.rst_done, s_reg.fail, s_reg.done, s_reg.busy}),
      .last_read   (s_reg.last),
      .busy        (s_reg.busy)
   );
   // the poll address doubles as the valid poll address
   fsp_bus_cycle u_cyc (
      .clk      (CLK_SYS),
      .rst      (RESET),
      .req_rd   (s_reg.req_rd),
      .req_wr   (s_reg.req_wr),
      .req_addr (poll_addr),
      .req_data (`FSP_CMD_RESET),
      .ack      (ack),
      .rd_data  (rd_data),
      .addr     (FLASH_ADDR),
      .ce_n     (FLASH_CE_N),
      .oe_n     (FLASH_OE_N),
      .we_n     (FLASH_WE_N),
      .dq_out   (FLASH_DQ_OUT),
      .dq_oe    (FLASH_DQ_OE),
      .dq_in    (FLASH_DQ_IN)
   );
   // erase and program polling both expect bit 7 of the programmed data word
   assign poll_ok = rd_data[`FSP_BIT_POLL] == prog_data[`FSP_BIT_POLL];
   assign toggled = rd_data[`FSP_BIT_TOGGLE] != s_reg.first[`FSP_BIT_TOGGLE];
   always_comb begin
      s_next = s_reg;
      s_next.req_rd = 1'b0;
      s_next.req_wr = 1'b0;
      unique case (s_reg.st)
         FSP_IDLE: begin
            if (start_pulse) begin
               s_next.busy = 1'b1;
               s_next.done = 1'b0;
               s_next.fail = 1'b0;
               s_next.rst_done = 1'b0;
               s_next.fail_seen = 1'b0;
               s_next.req_rd = 1'b1;
               s_next.st = FSP_RD1;
            end else if (reset_pulse) begin
               s_next.busy = 1'b1;
               s_next.rst_done = 1'b0;
               s_next.req_wr = 1'b1;
               s_next.st = FSP_WRRST;
            end
         end
         FSP_RD1: begin
            if (ack) begin
               s_next.first = rd_data;
               s_next.last = rd_data;
               s_next.req_rd = 1'b1;
               if (!use_toggle) begin
                  s_next.st = FSP_RD3;
               end else begin
                  s_next.st = FSP_RD2;
               end
            end
         end
         FSP_RD2: begin
            // toggle method: two back-to-back reads compared
            if (ack) begin
               s_next.last = rd_data;
               if (!toggled) begin
                  s_next.req_rd = 1'b1;
                  s_next.st = FSP_FINAL;
               end else if (s_reg.fail_seen) begin
                  s_next.fail = 1'b1;
                  s_next.req_wr = 1'b1;
                  s_next.st = FSP_WRRST;
               end else begin
                  s_next.fail_seen = rd_data[`FSP_BIT_FAIL];
                  s_next.first = rd_data;
                  s_next.req_rd = 1'b1;
                  s_next.st = FSP_RD2;
               end
            end
         end
         FSP_RD3: begin
            // data-complement method on the valid poll address
            if (ack) begin
               s_next.last = rd_data;
               if (poll_ok) begin
                  s_next.req_rd = 1'b1;
                  s_next.st = FSP_FINAL;
               end else if (s_reg.fail_seen) begin
                  s_next.fail = 1'b1;
                  s_next.req_wr = 1'b1;
                  s_next.st = FSP_WRRST;
               end else begin
                  s_next.fail_seen = rd_data[`FSP_BIT_FAIL];
                  s_next.req_rd = 1'b1;
               end
            end
         end
         FSP_FINAL: begin
            // later read returns fully valid array data
            if (ack) begin
               s_next.last = rd_data;
               s_next.st = FSP_EVAL;
            end
         end
         FSP_EVAL: begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.st = FSP_IDLE;
         end
         FSP_WRRST: begin
            if (ack) begin
               s_next.busy = 1'b0;
               s_next.done = 1'b1;
               s_next.rst_done = 1'b1;
               s_next.st = FSP_IDLE;
            end
         end
         default: s_next.st = FSP_IDLE;
      endcase
   end
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: logic/fsp_defines.svh */
// constants for the flash status polling controller
// Summary of operation
// - host polls a program at the programmed address only.
// - host polls erase status at an address inside a selected sector.
// - poll bit may change before low bits; take data from a later read.
// - after timeout fail bit seen high, read the poll bit once more.
// - toggle polling starts with two back-to-back reads compared.
// - toggling with fail bit high: recheck; still toggling means failure, reset.
// - a paused toggle poll restarts from the initial double read.
// - reset command is one write of F0 at any address.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
// register byte offsets
`define FSP_OFF_CTRL     12'h000
`define FSP_OFF_ADDR     12'h004
`define FSP_OFF_DATA     12'h008
`define FSP_OFF_STATUS   12'h00C
`define FSP_OFF_RDATA    12'h010
// control fields
`define FSP_CTRL_START   0
`define FSP_CTRL_METHOD  1
`define FSP_CTRL_RESET   2
// status fields
`define FSP_ST_BUSY      0
`define FSP_ST_DONE      1
`define FSP_ST_FAIL      2
`define FSP_ST_RESETDONE 3
// data bit positions
`define FSP_BIT_POLL     7
`define FSP_BIT_TOGGLE   6
`define FSP_BIT_FAIL     5
// reset command value
`define FSP_CMD_RESET    16'h00F0
// bus cycle timing: 70 ns address-to-data, 30 ns write strobe
`define FSP_T_READ_NS    70
`define FSP_T_WRITE_NS   30
`define FSP_CLK_NS       8
`define FSP_RD_CYC ((`FSP_T_READ_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WR_CYC ((`FSP_T_WRITE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_CYC_W        4
`endif

/* File: logic/fsp_pkg.sv */
// types for the flash status polling controller
package fsp_pkg;
   typedef enum logic [3:0] {
      FSP_IDLE   = 4'b0000,
      FSP_RD1    = 4'b0001,
      FSP_RD2    = 4'b0010,
      FSP_RD3    = 4'b0011,
      FSP_EVAL   = 4'b0100,
      FSP_WRRST  = 4'b0101,
      FSP_FINAL  = 4'b0110
   } fsp_state_t;
   typedef enum logic [1:0] {
      FSP_BUS_IDLE = 2'b00,
      FSP_BUS_RD   = 2'b01,
      FSP_BUS_WR   = 2'b10,
      FSP_BUS_END  = 2'b11
   } fsp_bus_state_t;
endpackage

/* File: logic/fsp_apb_slave.sv */
// apb register slave of the polling controller
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_apb_slave (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // register contents
   output logic             start_pulse,
   output logic             reset_pulse,
   output logic             use_toggle,
   output logic      [22:0] poll_addr,
   output logic      [15:0] prog_data,
   input  wire logic [3:0]  status,
   input  wire logic [15:0] last_read,
   input  wire logic        busy
);
   import fsp_pkg::*;
   typedef struct packed {
      logic        start;
      logic        rst_cmd;
      logic        method;
      logic [22:0] addr;
      logic [15:0] data;
      logic [31:0] rdata;
      logic        slverr;
   } fsp_apb_st_t;
   fsp_apb_st_t s_reg;
   fsp_apb_st_t s_next;
   logic        acc;
   always_comb begin
      s_next = s_reg;
      s_next.start = 1'b0;
      s_next.rst_cmd = 1'b0;
      acc = psel && penable;
      if (psel && !penable) begin
         s_next.slverr = 1'b0;
         s_next.rdata = 32'h00000000;
         unique case (paddr)
            `FSP_OFF_CTRL:   s_next.rdata = {31'h00000000, s_reg.method} << 1;
            `FSP_OFF_ADDR:   s_next.rdata = {9'h000, s_reg.addr};
            `FSP_OFF_DATA:   s_next.rdata = {16'h0000, s_reg.data};
            `FSP_OFF_STATUS: s_next.rdata = {28'h0000000, status};
            `FSP_OFF_RDATA:  s_next.rdata = {16'h0000, last_read};
            default:         s_next.slverr = 1'b1;
         endcase
      end
      if (acc && pwrite && !s_reg.slverr) begin
         unique case (paddr)
            `FSP_OFF_CTRL: begin
               s_next.method = pwdata[`FSP_CTRL_METHOD];
               s_next.start = pwdata[`FSP_CTRL_START] && !busy;
               s_next.rst_cmd = pwdata[`FSP_CTRL_RESET] && !busy;
            end
            `FSP_OFF_ADDR: s_next.addr = pwdata[22:0];
            `FSP_OFF_DATA: s_next.data = pwdata[15:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   // no wait states: setup cycle decodes, access completes at once
   assign pready = 1'b1;
   assign prdata = s_reg.rdata;
   // registered flag decoded in setup; it only counts in the access phase
   assign pslverr = s_reg.slverr;
   assign start_pulse = s_reg.start;
   assign reset_pulse = s_reg.rst_cmd;
   assign use_toggle = s_reg.method;
   assign poll_addr = s_reg.addr;
   assign prog_data = s_reg.data;
endmodule

/* File: logic/fsp_bus_cycle.sv */
// one asynchronous flash read or write cycle
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_bus_cycle (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // request
   input  wire logic        req_rd,
   input  wire logic        req_wr,
   input  wire logic [22:0] req_addr,
   input  wire logic [15:0] req_data,
   output logic             ack,
   output logic      [15:0] rd_data,
   // flash pins
   output logic      [22:0] addr,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic      [15:0] dq_out,
   output logic             dq_oe,
   input  wire logic [15:0] dq_in
);
   import fsp_pkg::*;
   typedef struct packed {
      fsp_bus_state_t        st;
      logic [`FSP_CYC_W-1:0] cnt;
      logic                  ack;
      logic [15:0]           rd;
      logic [22:0]           addr;
      logic                  ce_n;
      logic                  oe_n;
      logic                  we_n;
      logic [15:0]           dq;
      logic                  dq_oe;
   } fsp_cyc_st_t;
   fsp_cyc_st_t s_reg;
   fsp_cyc_st_t s_next;
   always_comb begin
      s_next = s_reg;
      s_next.ack = 1'b0;
      unique case (s_reg.st)
         FSP_BUS_IDLE: begin
            s_next.cnt = '0;
            if (req_rd) begin
               s_next.st = FSP_BUS_RD;
               s_next.addr = req_addr;
               s_next.ce_n = 1'b0;
               s_next.oe_n = 1'b0;
            end else if (req_wr) begin
               s_next.st = FSP_BUS_WR;
               s_next.addr = req_addr;
               s_next.dq = req_data;
               s_next.dq_oe = 1'b1;
               s_next.ce_n = 1'b0;
               s_next.we_n = 1'b0;
            end
         end
         FSP_BUS_RD: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            // all sixteen lines sampled, bits picked by position later
            if (s_reg.cnt == `FSP_CYC_W'(`FSP_RD_CYC)) begin
               s_next.rd = dq_in;
               s_next.st = FSP_BUS_END;
               s_next.ce_n = 1'b1;
               s_next.oe_n = 1'b1;
               s_next.ack = 1'b1;
            end
         end
         FSP_BUS_WR: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == `FSP_CYC_W'(`FSP_WR_CYC)) begin
               s_next.st = FSP_BUS_END;
               s_next.ce_n = 1'b1;
               s_next.we_n = 1'b1;
               s_next.ack = 1'b1;
            end
         end
         FSP_BUS_END: begin
            // data hold and recovery so that each read is a distinct cycle
            s_next.dq_oe = 1'b0;
            s_next.st = FSP_BUS_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.ce_n <= 1'b1;
         s_reg.oe_n <= 1'b1;
         s_reg.we_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   assign ack = s_reg.ack;
   assign rd_data = s_reg.rd;
   assign addr = s_reg.addr;
   assign ce_n = s_reg.ce_n;
   assign oe_n = s_reg.oe_n;
   assign we_n = s_reg.we_n;
   assign dq_out = s_reg.dq;
   assign dq_oe = s_reg.dq_oe;
endmodule

/* File: tb/fsp_poll_ctrl_monitor.sv */
// checker on the ports of the polling controller
`timescale 1ns/1ps
module fsp_poll_ctrl_monitor (
   // clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   // apb
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   // flash pins
   input wire logic [22:0] FLASH_ADDR,
   input wire logic        FLASH_CE_N,
   input wire logic        FLASH_OE_N,
   input wire logic        FLASH_WE_N,
   input wire logic [15:0] FLASH_DQ_OUT,
   input wire logic        FLASH_DQ_OE,
   input wire logic [15:0] FLASH_DQ_IN
);
   logic        oe_q_reg;
   logic        fail_seen_reg;
   logic [22:0] addr_reg;
   logic [3:0]  reads_reg;
   logic [3:0]  after_fail_reg;
   wire         apb_wr = PSEL && PENABLE && PWRITE;
   wire         rd_start = !FLASH_OE_N && oe_q_reg;
   // counters saturate so a long poll cannot wrap back below the bound
   always_ff @(posedge CLK_SYS) begin
      oe_q_reg <= FLASH_OE_N;
      if (RESET) begin
         addr_reg <= 23'h0;
         reads_reg <= 4'h0;
         after_fail_reg <= 4'h0;
         fail_seen_reg <= 1'b0;
      end else begin
         if (apb_wr && PADDR == 12'h004) addr_reg <= PWDATA[22:0];
         if (apb_wr && PADDR == 12'h000) begin
            reads_reg <= 4'h0;
            after_fail_reg <= 4'h0;
            fail_seen_reg <= 1'b0;
         end else begin
            if (rd_start && reads_reg != 4'hF) reads_reg <= reads_reg + 4'h1;
            if (rd_start && fail_seen_reg && after_fail_reg != 4'hF)
               after_fail_reg <= after_fail_reg + 4'h1;
            if (!FLASH_OE_N && FLASH_DQ_IN[5]) fail_seen_reg <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   sequence rd_low;
      !FLASH_OE_N && !FLASH_CE_N;
   endsequence
   sequence rd_rest;
      ##1 rd_low [*8] ##1 rd_low ##1 (FLASH_OE_N && FLASH_CE_N);
   endsequence
   sequence wr_rest;
      ##1 (!FLASH_WE_N) [*4] ##1 (FLASH_WE_N && FLASH_DQ_OE) ##1 !FLASH_DQ_OE;
   endsequence
   a_read_length: assert property ($fell(FLASH_OE_N) |-> rd_rest)
      else $error("read cycle length wrong");
   a_read_pair: assert property ($fell(FLASH_OE_N) |->
      $fell(FLASH_CE_N) && FLASH_WE_N) else $error("read strobes not paired");
   a_addr_valid: assert property (!FLASH_CE_N |->
      FLASH_ADDR == addr_reg) else $error("flash address not poll address");
   a_no_contend: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE)
      else $error("data driven during read");
   a_reset_cmd: assert property ($fell(FLASH_WE_N) |->
      (FLASH_OE_N && FLASH_DQ_OE && FLASH_DQ_OUT[7:0] == 8'hF0) ##0 wr_rest)
      else $error("reset write malformed");
   a_fail_recheck: assert property ($fell(FLASH_WE_N) && fail_seen_reg |->
      after_fail_reg != 4'h0) else $error("no recheck after fail");
   a_double_read: assert property ($fell(FLASH_WE_N) && fail_seen_reg |->
      reads_reg >= 4'h3) else $error("too few reads before reset");
   a_start_read: assert property (apb_wr && PADDR == 12'h000 &&
      PWDATA[0] && !PWDATA[2] |-> ##[1:4] $fell(FLASH_OE_N))
      else $error("poll did not start with a read");
endmodule
bind fsp_poll_ctrl fsp_poll_ctrl_monitor fsp_poll_ctrl_monitor_inst (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .FLASH_ADDR(FLASH_ADDR), .FLASH_CE_N(FLASH_CE_N),
   .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N),
   .FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE(FLASH_DQ_OE),
   .FLASH_DQ_IN(FLASH_DQ_IN));

/* File: tb/fsp_flash_model.sv */
// behavioural flash device answering status reads
`timescale 1ns/1ps
module fsp_flash_model (
   // flash pins
   input  wire logic [22:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [15:0] dq_out,
   input  wire logic        dq_oe,
   output logic      [15:0] dq_in,
   // scenario control
   input  wire logic        start,
   input  wire logic        erase,
   input  wire logic        fail_mode,
   input  wire logic        suspend,
   input  wire logic [3:0]  busy_reads,
   input  wire logic [15:0] word,
   output logic      [7:0]  n_reads,
   output logic      [7:0]  n_resets,
   output logic      [22:0] rst_addr
);
   logic        busy = 0, tog = 0, tog2 = 0, fail = 0;
   logic        in_rd = 0, in_wr = 0;
   logic [3:0]  left = 0;
   logic [15:0] st, drv, held = 0;
   initial n_reads = 0;
   initial n_resets = 0;
   initial rst_addr = 0;
   // a released bus shows the inverse of the last word read, never a stale copy
   always @* begin
      st = ~word;
      st[7] = erase ? suspend : ~word[7];
      st[6] = tog;
      st[5] = fail;
      st[3] = erase;
      st[2] = erase ? tog2 : st[2];
      drv = busy ? st : word;
      dq_in = (ce_n || oe_n) ? ~held : drv;
   end
   always @(posedge start) begin
      busy = 1;
      tog = 0;
      tog2 = 0;
      fail = 0;
      left = busy_reads;
      n_reads = 0;
      n_resets = 0;
   end
   // dq_oe may settle after the strobes in the same step
   always @(negedge ce_n or negedge oe_n or negedge we_n or posedge dq_oe) begin
      in_rd = !ce_n && !oe_n && we_n;
      in_wr = !ce_n && !we_n && dq_oe;
   end
   always @(posedge ce_n or posedge oe_n or posedge we_n) begin
      if (in_rd) begin
         n_reads = n_reads + 1;
         held = drv;
         if (busy) begin
            tog2 = ~tog2;
            // a suspended erase freezes the countdown and the global toggle
            if (!suspend) begin
               tog = ~tog;
               if (left > 0) left = left - 1;
               if (left == 0 && fail_mode) fail = 1;
               else if (left == 0) busy = 0;
            end
         end
      end
      if (in_wr && dq_out[7:0] == 8'hF0) begin
         busy = 0;
         fail = 0;
         n_resets = n_resets + 1;
         rst_addr = addr;
      end
      in_rd = 0;
      in_wr = 0;
   end
endmodule

/* File: tb/test_flash_write_status_polling.sv */
// self-checking bench for the flash status polling controller
`timescale 1ns/1ps
module test_flash_write_status_polling;
   logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, ce_n, oe_n, we_n, dq_oe, err;
   logic        m_start = 0, m_erase = 0, m_fail = 0, m_susp = 0;
   logic [3:0]  m_busy = 0;
   logic [7:0]  n_reads, n_resets;
   logic [11:0] paddr = 0;
   logic [15:0] dq_out, dq_in, word = 0;
   logic [22:0] faddr, rst_addr;
   logic [31:0] pwdata = 0, prdata, rd;
   int          mismatches = 0, check_count = 0;
   initial forever #4 clk_sys = ~clk_sys;
   fsp_poll_ctrl fsp_poll_ctrl_inst (
      .CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .FLASH_ADDR(faddr),
      .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n),
      .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq_in));
   fsp_flash_model fsp_flash_model_inst (
      .addr(faddr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .start(m_start), .erase(m_erase),
      .fail_mode(m_fail), .suspend(m_susp), .busy_reads(m_busy), .word(word),
      .n_reads(n_reads), .n_resets(n_resets), .rst_addr(rst_addr));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   // the wait on pready is bounded only by the watchdog
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic e, f, t, input logic [3:0] n,
                      input logic [15:0] w, input logic [22:0] a);
      int k;
      m_erase <= e;
      m_fail <= f;
      m_busy <= n;
      word <= w;
      apb(1'b1, 12'h004, {9'h0, a});
      apb(1'b1, 12'h008, {16'h0, w});
      m_start <= 1'b1;
      apb(1'b1, 12'h000, {30'h0, t, 1'b1});
      m_start <= 1'b0;
      k = 0;
      do begin
         apb(1'b0, 12'h00C, 32'h0);
         k++;
      end while (rd[0] === 1'b1 && k < 500);
      // a poll that never finishes counts as a mismatch and ends the run
      if (rd[0] !== 1'b0) begin
         mismatches++;
         summarize;
      end
   endtask
   task automatic test_idle;
      int k;
      apb(1'b0, 12'h00C, 32'h0);
      check(rd, 32'h0);
      check({ce_n, oe_n, we_n, dq_oe}, 32'hE);
      apb(1'b0, 12'h014, 32'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h1);
      apb(1'b1, 12'h004, 32'h00_5A5A);
      apb(1'b1, 12'h000, 32'h4);
      for (k = 0; k < 100 && n_resets == 0; k++) @(posedge clk_sys);
      check(32'(n_resets), 32'h1);
      check(32'(rst_addr), 32'h5A5A);
      apb(1'b0, 12'h00C, 32'h0);
      check(rd & 32'h8, 32'h8);
      $display("test_idle done");
   endtask
   task automatic test_success;
      int i, exp;
      for (i = 0; i < 4; i++) begin
         run(i[1], 1'b0, i[0], 4'(3 + i), i[1] ? 16'hFFFF : 16'h00A5,
             23'(24'h1234 + i));
         exp = 5 + i;
         if (i[0] && ((2 + i) % 2) != i[1]) exp++;
         check(rd & 32'h7, 32'h2);
         check(32'(n_reads), 32'(exp));
         apb(1'b0, 12'h010, 32'h0);
         check(rd, {16'h0, word});
      end
      $display("test_success done");
   endtask
   // suspended erase: toggle frozen and poll bit 1, so the poll ends early
   task automatic test_suspend;
      int i;
      m_susp <= 1'b1;
      for (i = 0; i < 2; i++) begin
         run(1'b1, 1'b0, i[0], 4'h4, 16'hFFFF, 23'(24'h2000 + i));
         check(rd & 32'h7, 32'h2);
         check(32'(n_reads), 32'h3);
      end
      m_susp <= 1'b0;
      $display("test_suspend done");
   endtask
   task automatic test_fail;
      int i;
      for (i = 0; i < 2; i++) begin
         run(i[0], 1'b1, i[0], 4'h2, i[0] ? 16'hFFFF : 16'h00A5,
             23'(24'h7F0001 - i));
         check(rd & 32'hD, 32'hC);
         check(32'(n_resets), 32'h1);
         check(32'(rst_addr), 32'(24'h7F0001 - i));
      end
      $display("test_fail done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      test_idle;
      test_success;
      test_suspend;
      test_fail;
      summarize;
   end
   // a full run needs well under a tenth of this
   initial begin
      repeat (40000) @(posedge clk_sys);
      mismatches++;
      summarize;
   end
endmodule
